/* udc_regs.vh */
`ifndef UDC_REGS_VH
`define UDC_REGS_VH

`define UDC_OFS_CTL        8'h40
`define UDC_OFS_FLAGS      8'h44
`define UDC_OFS_STAT       8'h48
`define UDC_OFS_ADDR       8'h4C

`define UDC_CTL_RESET      16'h0003
`define UDC_CTL_MASK       16'hFFBF

`define UDC_B_SOFT_RST     0
`define UDC_B_CLOSE        1
`define UDC_B_LOWPWR       2
`define UDC_B_SUSPEND      3
`define UDC_B_RESUME       4
`define UDC_B_LPM_RESUME   5
`define UDC_B_LPM          7
`define UDC_B_MISSED       8
`define UDC_B_SOF          9
`define UDC_B_BUSRST       10
`define UDC_B_SUSP_FLAG    11
`define UDC_B_WAKE         12
`define UDC_B_ERROR        13
`define UDC_B_PKTMEM       14
`define UDC_B_XFER         15
`define UDC_B_DIR          4

`define UDC_W0C_MASK       16'h7F80
`define UDC_ADDR_MASK      8'hFF
`define UDC_LOCK_SOFS      2'h2

`define UDC_IDLE_TIME_US   3000
`define UDC_CLK_MHZ        10
`define UDC_RESUME_TIME_US 10
`define UDC_LPM_TIME_US    50

`endif

/* udc_ctrl_status.v */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "udc_regs.vh"

// Functional notes
// R1: lpm resume bit sends l1 resume signalling, hardware clears it when done
// R2: resume bit set drives a resume request toward the host
// R3: suspend-set bit places device in suspend
// R4: low-power bit enters low power in suspend; hardware clears it on bus activity in suspend
// R5: close bit shuts device down and disconnects from host
// R6: soft reset bit holds the core in reset
// R7: missed-frame, lpm and frame-start enables gate their interrupts
// R8: transfer-done flag set on every successful transaction, read only
// R9: packet memory overrun flag set by hardware, cleared by writing 0
// R10: error flag set on transaction error, cleared by writing 0
// R11: wake flag set on bus activity in suspend, cleared by writing 0
// R12: suspend flag set after 3 ms idle bus, cleared by writing 0
// R13: bus reset flag set on usb reset, cleared by writing 0
// R14: frame start flag set on each sof, cleared by writing 0
// R15: missed frame flag set when expected sof is absent, cleared by 0
// R16: lpm request flag set on acked l1 transaction, cleared by 0
// R17: direction bit reports latest transaction, 0 out and 1 in
// R18: four-bit endpoint field reports latest transaction endpoint
// R19: two status bits show live d+ and d- levels
// R20: lock bit set after two consecutive sofs
// R21: lost-frame counter counts missed frames, cleared on sof
// R22: frame number counter increments on every sof
// R23: interrupt only when flag and enable both set
// R24: writing 1 to a write-zero-clear flag leaves it unchanged
// R25: frame and lost-frame counters wrap to zero
module udc_ctrl_status #(
	parameter IDLE_CYCLES = `UDC_IDLE_TIME_US * `UDC_CLK_MHZ
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        ev_xfer_done,
	input  wire        ev_xfer_dir,
	input  wire [3:0]  ev_xfer_ep,
	input  wire        ev_pktmem_ovr,
	input  wire        ev_xact_error,
	input  wire        ev_bus_activity,
	input  wire        ev_bus_reset,
	input  wire        ev_sof,
	input  wire        ev_frame_tick,
	input  wire        ev_lpm_ack,
	input  wire        dplus_level,
	input  wire        dminus_level,
	output wire        irq,
	output wire        core_reset,
	output wire        core_close,
	output wire        suspended,
	output wire        low_power,
	output wire        resume_drive,
	output wire        lpm_resume_drive,
	output wire [6:0]  dev_addr,
	output wire        dev_enable
);

	localparam RES_CYCLES = `UDC_RESUME_TIME_US * `UDC_CLK_MHZ;
	localparam LPM_CYCLES = `UDC_LPM_TIME_US * `UDC_CLK_MHZ;

	localparam SIG_IDLE   = 2'b00;
	localparam SIG_RESUME = 2'b01;
	localparam SIG_LPM    = 2'b10;

	reg  [15:0] ctl;
	reg  [15:0] flags;
	reg  [3:0]  endpoint_index;
	reg         xfer_dir;
	reg  [10:0] frame_number;
	reg  [1:0]  frames_lost_count;
	reg  [1:0]  sof_run;
	reg  [7:0]  function_address;
	reg  [31:0] idle_cnt;
	reg  [15:0] sig_cnt;
	reg  [1:0]  sig_state;
	reg  [1:0]  next_sig_state;
	reg  [15:0] next_flags;
	reg  [15:0] ev_vec;

	wire wr_en = psel & penable & pwrite;
	wire lock  = (sof_run == `UDC_LOCK_SOFS); // [R20]

	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	assign core_reset       = ctl[`UDC_B_SOFT_RST]; // [R6]
	assign core_close       = ctl[`UDC_B_CLOSE]; // [R5]
	assign suspended        = ctl[`UDC_B_SUSPEND]; // [R3]
	assign low_power        = ctl[`UDC_B_SUSPEND] & ctl[`UDC_B_LOWPWR]; // [R4]
	assign resume_drive     = (sig_state == SIG_RESUME); // [R2]
	assign lpm_resume_drive = (sig_state == SIG_LPM); // [R1]
	assign dev_addr         = function_address[6:0];
	assign dev_enable       = function_address[7];
	// each enable gates only its own flag; the flags themselves set regardless
	wire en_xfer             = ctl[`UDC_B_XFER];
	wire en_pktmem           = ctl[`UDC_B_PKTMEM];
	wire en_error            = ctl[`UDC_B_ERROR];
	wire en_wake             = ctl[`UDC_B_WAKE];
	wire en_susp             = ctl[`UDC_B_SUSP_FLAG];
	wire en_busrst           = ctl[`UDC_B_BUSRST];
	wire frame_start_irq_en  = ctl[`UDC_B_SOF]; // [R7]
	wire missed_frame_irq_en = ctl[`UDC_B_MISSED]; // [R7]
	wire lpm_irq_en          = ctl[`UDC_B_LPM]; // [R7]
	wire irq_xfer            = flags[`UDC_B_XFER] & en_xfer; // [R23]
	wire irq_pktmem          = flags[`UDC_B_PKTMEM] & en_pktmem; // [R23]
	wire irq_error           = flags[`UDC_B_ERROR] & en_error; // [R23]
	wire irq_wake            = flags[`UDC_B_WAKE] & en_wake; // [R23]
	wire irq_susp            = flags[`UDC_B_SUSP_FLAG] & en_susp; // [R23]
	wire irq_busrst          = flags[`UDC_B_BUSRST] & en_busrst; // [R23]
	wire irq_sof             = flags[`UDC_B_SOF] & frame_start_irq_en; // [R7] [R23]
	wire irq_missed          = flags[`UDC_B_MISSED] & missed_frame_irq_en; // [R7] [R23]
	wire irq_lpm             = flags[`UDC_B_LPM] & lpm_irq_en; // [R7] [R23]
	assign irq = irq_xfer | irq_pktmem | irq_error
		| irq_wake | irq_susp | irq_busrst
		| irq_sof | irq_missed | irq_lpm; // [R7] [R23]

	wire set_xfer   = ev_xfer_done; // [R8]
	wire set_pktmem = ev_pktmem_ovr; // [R9]
	wire set_error  = ev_xact_error; // [R10]
	wire set_wake   = ev_bus_activity & ctl[`UDC_B_SUSPEND]; // [R11]
	wire set_susp   = ~ev_bus_activity & (idle_cnt == IDLE_CYCLES - 1); // [R12]
	wire set_busrst = ev_bus_reset; // [R13]
	wire set_sof    = ev_sof; // [R14]
	wire set_missed = ev_frame_tick & ~ev_sof; // [R15]
	wire set_lpm    = ev_lpm_ack; // [R16]

	always @* begin
		ev_vec = 16'h0000;
		ev_vec[`UDC_B_XFER]      = set_xfer; // [R8]
		ev_vec[`UDC_B_PKTMEM]    = set_pktmem; // [R9]
		ev_vec[`UDC_B_ERROR]     = set_error; // [R10]
		ev_vec[`UDC_B_WAKE]      = set_wake; // [R11]
		ev_vec[`UDC_B_SUSP_FLAG] = set_susp; // [R12]
		ev_vec[`UDC_B_BUSRST]    = set_busrst; // [R13]
		ev_vec[`UDC_B_SOF]       = set_sof; // [R14]
		ev_vec[`UDC_B_MISSED]    = set_missed; // [R15]
		ev_vec[`UDC_B_LPM]       = set_lpm; // [R16]
	end

	// set wins over a simultaneous write-zero clear
	always @* begin
		next_flags = flags;
		if (wr_en && hit(paddr, `UDC_OFS_FLAGS))
			next_flags = flags & (pwdata[15:0] | ~`UDC_W0C_MASK); // [R24]
		next_flags = next_flags | ev_vec;
	end

	always @* begin
		next_sig_state = sig_state;
		case (sig_state)
		SIG_IDLE: begin
			if (ctl[`UDC_B_LPM_RESUME])
				next_sig_state = SIG_LPM;
			else if (ctl[`UDC_B_RESUME])
				next_sig_state = SIG_RESUME;
		end
		SIG_RESUME: begin
			if (sig_cnt == RES_CYCLES - 1)
				next_sig_state = SIG_IDLE;
		end
		SIG_LPM: begin
			if (sig_cnt == LPM_CYCLES - 1)
				next_sig_state = SIG_IDLE;
		end
		default: next_sig_state = SIG_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sig_state <= SIG_IDLE;
		else
			sig_state <= next_sig_state;
	end

	// the burst timer restarts at every entry so a repeated resume gets a full burst
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sig_cnt <= 16'h0000;
		else if (sig_state == SIG_IDLE || next_sig_state == SIG_IDLE)
			sig_cnt <= 16'h0000;
		else
			sig_cnt <= sig_cnt + 16'h0001;
	end

	wire ctl_wr    = wr_en && hit(paddr, `UDC_OFS_CTL);
	wire addr_wr   = wr_en && hit(paddr, `UDC_OFS_ADDR);
	// hardware clears lose to a software write in the same cycle
	wire lpm_done  = (sig_state == SIG_LPM) && (next_sig_state == SIG_IDLE);
	wire wake_exit = ctl[`UDC_B_SUSPEND] && ev_bus_activity;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= `UDC_CTL_RESET;
		end else if (ctl_wr) begin
			ctl <= pwdata[15:0] & `UDC_CTL_MASK;
		end else begin
			if (lpm_done)
				ctl[`UDC_B_LPM_RESUME] <= 1'b0; // [R1]
			if (wake_exit)
				ctl[`UDC_B_LOWPWR] <= 1'b0; // [R4]
		end
	end

	// a bus reset returns to the default address but leaves the enable alone
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			function_address <= 8'h00;
		end else if (addr_wr) begin
			function_address <= pwdata[7:0] & `UDC_ADDR_MASK;
		end else if (ev_bus_reset) begin
			function_address[6:0] <= 7'h00;
		end
	end

	// soft reset holds the event side, so the core restarts from a clean frame state
	wire core_hold = ctl[`UDC_B_SOFT_RST]; // [R6]

	reg  [10:0] next_frame_number;
	reg  [1:0]  next_frames_lost_count;
	reg  [1:0]  next_sof_run;
	reg  [31:0] next_idle_cnt;

	always @* begin
		next_frame_number      = frame_number;
		next_frames_lost_count = frames_lost_count;
		next_sof_run           = sof_run;
		next_idle_cnt          = idle_cnt;
		if (core_hold) begin
			next_frame_number      = 11'h000;
			next_frames_lost_count = 2'h0;
			next_sof_run           = 2'h0;
			next_idle_cnt          = 32'h00000000;
		end else begin
			if (set_sof) begin
				next_frame_number      = frame_number + 11'h001; // [R22] [R25]
				next_frames_lost_count = 2'h0; // [R21]
				if (sof_run != `UDC_LOCK_SOFS)
					next_sof_run = sof_run + 2'h1; // [R20]
			end else if (set_missed) begin
				next_frames_lost_count = frames_lost_count + 2'h1; // [R21] [R25]
				next_sof_run           = 2'h0;
			end
			// the timer parks at its limit so one idle spell raises the flag only once
			if (ev_bus_activity || ctl[`UDC_B_CLOSE])
				next_idle_cnt = 32'h00000000;
			else if (idle_cnt != IDLE_CYCLES)
				next_idle_cnt = idle_cnt + 32'h00000001; // [R12]
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_number      <= 11'h000;
			frames_lost_count <= 2'h0;
			sof_run           <= 2'h0;
			idle_cnt          <= 32'h00000000;
		end else begin
			frame_number      <= next_frame_number;
			frames_lost_count <= next_frames_lost_count;
			sof_run           <= next_sof_run;
			idle_cnt          <= next_idle_cnt;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= 16'h0000;
		end else if (core_hold) begin
			flags <= 16'h0000; // [R6]
		end else begin
			flags <= next_flags;
		end
	end

	// direction and endpoint follow the latest good transaction only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			endpoint_index <= 4'h0;
			xfer_dir       <= 1'b0;
		end else if (!core_hold && ev_xfer_done) begin
			endpoint_index <= ev_xfer_ep; // [R18]
			xfer_dir       <= ev_xfer_dir; // [R17]
		end
	end

	wire [15:0] rd_ctl;
	wire [15:0] rd_flags;
	wire [15:0] rd_stat;

	// the reserved control bit always reads back as zero
	assign rd_ctl[15:7]                = ctl[15:7]; // [R7]
	assign rd_ctl[6]                   = 1'b0;
	assign rd_ctl[`UDC_B_LPM_RESUME]   = ctl[`UDC_B_LPM_RESUME]; // [R1]
	assign rd_ctl[`UDC_B_RESUME]       = ctl[`UDC_B_RESUME]; // [R2]
	assign rd_ctl[`UDC_B_SUSPEND]      = ctl[`UDC_B_SUSPEND]; // [R3]
	assign rd_ctl[`UDC_B_LOWPWR]       = ctl[`UDC_B_LOWPWR]; // [R4]
	assign rd_ctl[`UDC_B_CLOSE]        = ctl[`UDC_B_CLOSE]; // [R5]
	assign rd_ctl[`UDC_B_SOFT_RST]     = ctl[`UDC_B_SOFT_RST]; // [R6]
	assign rd_flags[15:7]              = flags[15:7];
	assign rd_flags[6:5]               = 2'b00;
	assign rd_flags[`UDC_B_DIR]        = xfer_dir; // [R17]
	assign rd_flags[3:0]               = endpoint_index; // [R18]
	assign rd_stat[15]                 = dplus_level; // [R19]
	assign rd_stat[14]                 = dminus_level; // [R19]
	assign rd_stat[13]                 = lock; // [R20]
	assign rd_stat[12:11]              = frames_lost_count; // [R21]
	assign rd_stat[10:0]               = frame_number; // [R22]

	always @* begin
		prdata = 32'h00000000;
		case (paddr)
		`UDC_OFS_CTL:   prdata[15:0] = rd_ctl;
		`UDC_OFS_FLAGS: prdata[15:0] = rd_flags;
		`UDC_OFS_STAT:  prdata[15:0] = rd_stat; // [R19]
		`UDC_OFS_ADDR:  prdata[7:0]  = function_address;
		default:        prdata = 32'h00000000;
		endcase
	end

endmodule // udc_ctrl_status

/* udc_chk_assertions.sv */
`timescale 1ns/1ps
module udc_chk(
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        ev_bus_activity,
	input logic        dplus_level,
	input logic        dminus_level,
	input logic        irq,
	input logic        core_reset,
	input logic        core_close,
	input logic        suspended,
	input logic        low_power,
	input logic        lpm_resume_drive
);
	wire cw = psel && penable && pwrite && paddr == 8'h40;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SRST: assert property (cw |=> core_reset == $past(pwdata[0])) else $error("soft reset");
	AST_CLOSE: assert property (cw |=> core_close == $past(pwdata[1])) else $error("close");
	AST_SUSP: assert property (cw |=> suspended == $past(pwdata[3])) else $error("suspend");
	AST_IRQ: assert property (cw && pwdata[15:7] == 9'h000 |=> !irq) else $error("irq");
	AST_LPWR: assert property (low_power |-> suspended) else $error("low power");
	// a ctl write in the same cycle may set the bit again, so it is excluded
	AST_WAKE: assert property (suspended && ev_bus_activity && !cw |=> !low_power) else $error("wake");
	AST_LINE: assert property (psel && !pwrite && paddr == 8'h48 |-> prdata[15:14] == {dplus_level, dminus_level})
		else $error("lines");
	AST_LPMR: assert property ($rose(lpm_resume_drive) |-> lpm_resume_drive[*8]) else $error("lpm resume");
endmodule // udc_chk

/* udc_host.sv */
`timescale 1ns/1ps
module udc_host(
	input logic        pclk,
	output logic [7:0] ev,
	output logic       dir,
	output logic [3:0] ep,
	output logic [1:0] line
);
	initial begin
		ev = 8'h00;
		dir = 1'b0;
		ep = 4'h0;
		line = 2'b10;
	end
	// qualifiers are scrambled after the event so stale values never pass
	task pulse(input [7:0] m, input d, input [3:0] e);
		@(posedge pclk);
		ev <= m;
		dir <= d;
		ep <= e;
		@(posedge pclk);
		ev <= 8'h00;
		dir <= ~d;
		ep <= ~e;
	endtask
	task lines(input [1:0] v);
		@(posedge pclk);
		line <= v;
	endtask
endmodule // udc_host

/* usb_device_ctrl_status_test.sv */
`timescale 1ns/1ps
bind udc_ctrl_status udc_chk chk_u(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.ev_bus_activity, .dplus_level, .dminus_level, .irq, .core_reset, .core_close, .suspended, .low_power,
	.lpm_resume_drive);
module usb_device_ctrl_status_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	wire pready, pslverr, irq, core_reset, core_close, suspended, low_power, resume_drive, lpm_resume_drive, dev_enable;
	wire [6:0] dev_addr;
	wire [7:0] ev;
	wire dir;
	wire [3:0] ep;
	wire [1:0] line;
	int n_errors = 0, tests_run = 0;
	udc_ctrl_status #(.IDLE_CYCLES(20)) dut_u(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .ev_xfer_done(ev[7]), .ev_xfer_dir(dir), .ev_xfer_ep(ep), .ev_pktmem_ovr(ev[6]),
		.ev_xact_error(ev[5]), .ev_bus_activity(ev[4]), .ev_bus_reset(ev[3]), .ev_sof(ev[2]), .ev_frame_tick(ev[1]),
		.ev_lpm_ack(ev[0]), .dplus_level(line[1]), .dminus_level(line[0]), .irq, .core_reset, .core_close,
		.suspended, .low_power, .resume_drive, .lpm_resume_drive, .dev_addr, .dev_enable);
	udc_host host_u(.pclk, .ev, .dir, .ep, .line);
	initial forever #50 pclk = ~pclk;
	task report_and_stop;
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task ck(input string nm, input [31:0] e, input [31:0] s);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task xf(input w, input [7:0] a, input [31:0] d, input [31:0] m, input [31:0] e);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_errors++;
			report_and_stop;
		end
		psel <= 0;
		penable <= 0;
		if (!w) ck($sformatf("reg %h", a), e, prdata & m);
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xf(1, a, d, 0, 0);
	endtask
	task rd(input [7:0] a, input [31:0] m, input [31:0] e);
		xf(0, a, 0, m, e);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		rd(8'h40, 32'hFFFF, 32'h0003);
		rd(8'h44, 32'hFFFF, 32'h0000);
		rd(8'h50, 32'hFFFFFFFF, 32'h0);
		wr(8'h40, 32'h0002);
		repeat (2) host_u.pulse(8'h04, 0, 0);
		rd(8'h48, 32'h3FFF, 32'h2002);
		rd(8'h44, 32'h0300, 32'h0200);
		host_u.pulse(8'h02, 0, 0);
		rd(8'h48, 32'h3FFF, 32'h0802);
		rd(8'h44, 32'h0300, 32'h0300);
		wr(8'h44, 32'hFDFF);
		rd(8'h44, 32'h0300, 32'h0100);
		host_u.pulse(8'hE9, 1, 5);
		rd(8'h44, 32'hE49F, 32'hE495);
		wr(8'h44, 32'h0);
		rd(8'h44, 32'hFF80, 32'h8000);
		wr(8'h40, 32'h0202);
		host_u.pulse(8'h04, 0, 0);
		@(posedge pclk);
		ck("irq", 1, irq);
		wr(8'h40, 32'h0002);
		@(posedge pclk);
		ck("irq", 0, irq);
		wr(8'h40, 32'h0);
		repeat (30) @(posedge pclk);
		rd(8'h44, 32'h0800, 32'h0800);
		wr(8'h40, 32'h000C);
		@(posedge pclk);
		ck("low_power", 1, low_power);
		host_u.pulse(8'h10, 0, 0);
		rd(8'h44, 32'h1000, 32'h1000);
		rd(8'h40, 32'h000C, 32'h0008);
		wr(8'h40, 32'h0010);
		repeat (2) @(posedge pclk);
		ck("resume_drive", 1, resume_drive);
		// lpm signalling starts only after the running resume burst ends
		wr(8'h40, 32'h0020);
		repeat (100) @(posedge pclk);
		ck("lpm_resume_drive", 1, lpm_resume_drive);
		ck("resume_drive", 0, resume_drive);
		repeat (520) @(posedge pclk);
		rd(8'h40, 32'h0020, 32'h0);
		host_u.lines(2'b01);
		rd(8'h48, 32'hC000, 32'h4000);
		wr(8'h4C, 32'h0085);
		rd(8'h4C, 32'h00FF, 32'h0085);
		ck("dev_addr", 32'h05, dev_addr);
		ck("dev_enable", 1, dev_enable);
		host_u.pulse(8'h08, 0, 0);
		rd(8'h4C, 32'h00FF, 32'h0080);
		ck("core_close", 0, core_close);
		ck("pslverr", 0, pslverr);
		report_and_stop;
	end
endmodule // usb_device_ctrl_status_test
